/* File: logic/prom_programmer.sv */
`timescale 1ns/10ps
`include "prom_prog_map.svh"
// What this block does
// - Hold device reset low, raise supply level.
// - Output enable reads the selected device and also latches page bytes with chip enable high.
// - One 0.1 ms pulse programs the page.
// - Read back and compare after each pulse.
// - Byte program pulse with chip enable low.
// - Retry pulse and verify, ten pulses maximum.
// - Seventeen address lines, eight-bit data bus.
module prom_programmer (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Command side.
    input  wire logic                     cmd_valid,
    input  wire prom_prog_pkg::cmd_t      cmd,
    output logic                          cmd_ready,
    output logic                          done,
    output prom_prog_pkg::result_t        result,
    // Device pins.
    output prom_prog_pkg::strobes_t       pins,
    output logic [`ADDR_W-1:0]            address_bus,
    output logic [`DATA_W-1:0]            data_bus_out,
    output logic                          data_bus_oe,
    input  wire logic [`DATA_W-1:0]       data_bus_in
);

    typedef enum logic [3:0] {
        S_IDLE,
        S_LATCH_SETUP,
        S_LATCH_STROBE,
        S_PULSE,
        S_GAP,
        S_VERIFY_SETUP,
        S_VERIFY_SAMPLE,
        S_DONE
    } state_t;

    // The counter runs down to zero inclusive, so one less keeps the pulse exact.
    localparam logic [16:0] PULSE_LEN = 17'(`PULSE_CYCLES - 1);
    localparam logic [16:0] SETUP_LEN = 17'(`SETUP_CYCLES);

    state_t                  state_q, state_d;
    prom_prog_pkg::cmd_t     cmd_q;
    prom_prog_pkg::result_t  result_q, result_d;
    prom_prog_pkg::strobes_t pins_q, pins_d;
    logic [16:0]             count_q, count_d;
    logic [1:0]              byte_q, byte_d;
    logic [`ADDR_W-1:0]      addr_q, addr_d;
    logic [`DATA_W-1:0]      dout_q, dout_d;
    logic                    oe_q, oe_d;
    logic                    ready_q, ready_d;
    logic                    done_q, done_d;
    logic                    fail_seen_q, fail_seen_d;

    // Byte lane of the held page word.
    function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] i);
        lane = w[8*i +: 8];
    endfunction

    wire        is_page   = cmd_q.op == prom_prog_pkg::OP_PAGE_PROGRAM;
    wire        is_read   = cmd_q.op == prom_prog_pkg::OP_READ;
    wire        count_end = count_q == 17'h0_0000;
    wire [7:0]  expect_b  = lane(cmd_q.data, is_page ? byte_q : 2'h0);
    wire        mismatch  = data_bus_in != expect_b;
    wire        last_byte = !is_page || byte_q == 2'(`PAGE_BYTES - 1);
    wire        out_of_pulses = result_q.pulses == 4'(`MAX_PULSES);
    wire [16:0] page_base = {cmd_q.addr[16:2], 2'b00};

    // Idle strobes: enables and program strobe inactive, reset held low and supply high, so the device floats its data pins.
    wire prom_prog_pkg::strobes_t idle_pins = '{chip_enable_n: 1'b1, output_enable_n: 1'b1,
        program_strobe_n: 1'b1, reset_n: 1'b0, vpp_high: 1'b1};

    always_comb begin
        state_d     = state_q;
        result_d    = result_q;
        pins_d      = pins_q;
        count_d     = count_q == 17'h0_0000 ? count_q : count_q - 17'h0_0001;
        byte_d      = byte_q;
        addr_d      = addr_q;
        dout_d      = dout_q;
        oe_d        = oe_q;
        ready_d     = 1'b0;
        done_d      = 1'b0;
        fail_seen_d = fail_seen_q;
        unique case (state_q)
            S_IDLE: begin
                pins_d  = idle_pins;
                oe_d    = 1'b0;
                ready_d = 1'b1;
                if (cmd_valid && ready_q) begin
                    ready_d        = 1'b0;
                    result_d       = '0;
                    byte_d         = 2'h0;
                    fail_seen_d    = 1'b0;
                    count_d        = SETUP_LEN;
                    state_d        = cmd.op == prom_prog_pkg::OP_READ ? S_VERIFY_SETUP
                                   : cmd.op == prom_prog_pkg::OP_PAGE_PROGRAM ? S_LATCH_SETUP
                                   : S_PULSE;
                    addr_d         = cmd.op == prom_prog_pkg::OP_PAGE_PROGRAM
                                   ? {cmd.addr[16:2], 2'b00} : cmd.addr;
                    dout_d         = cmd.data[7:0];
                    if (cmd.op == prom_prog_pkg::OP_READ) begin
                        pins_d.chip_enable_n   = 1'b0;
                        pins_d.output_enable_n = 1'b0;
                    end else if (cmd.op == prom_prog_pkg::OP_BYTE_PROGRAM) begin
                        oe_d                 = 1'b1;
                        pins_d.chip_enable_n = 1'b0;
                        count_d              = PULSE_LEN;
                        pins_d.program_strobe_n = 1'b0;
                        result_d.pulses      = 4'h1;
                    end else begin
                        oe_d = 1'b1;
                    end
                end
            end
            S_LATCH_SETUP: begin
                if (count_end) begin
                    pins_d.output_enable_n = 1'b0;
                    count_d = SETUP_LEN;
                    state_d = S_LATCH_STROBE;
                end
            end
            S_LATCH_STROBE: begin
                if (count_end) begin
                    pins_d.output_enable_n = 1'b1;
                    count_d = SETUP_LEN;
                    if (byte_q == 2'(`PAGE_BYTES - 1)) begin
                        addr_d  = page_base;
                        count_d = PULSE_LEN;
                        pins_d.program_strobe_n = 1'b0;
                        result_d.pulses = result_q.pulses + 4'h1;
                        oe_d    = 1'b0;
                        state_d = S_PULSE;
                    end else begin
                        byte_d  = byte_q + 2'h1;
                        addr_d  = page_base + 17'(byte_q + 2'h1);
                        dout_d  = lane(cmd_q.data, byte_q + 2'h1);
                        state_d = S_LATCH_SETUP;
                    end
                end
            end
            S_PULSE: begin
                oe_d = !is_page;
                if (count_end) begin
                    pins_d.program_strobe_n = 1'b1;
                    count_d = SETUP_LEN;
                    byte_d  = 2'h0;
                    state_d = S_GAP;
                end
            end
            S_GAP: begin
                if (count_end) begin
                    oe_d    = 1'b0;
                    addr_d  = is_page ? page_base : addr_q;
                    pins_d.chip_enable_n   = 1'b0;
                    pins_d.output_enable_n = 1'b0;
                    count_d = SETUP_LEN;
                    state_d = S_VERIFY_SETUP;
                end
            end
            S_VERIFY_SETUP: begin
                if (count_end) begin
                    state_d = S_VERIFY_SAMPLE;
                end
            end
            S_VERIFY_SAMPLE: begin
                count_d = SETUP_LEN;
                if (is_read) begin
                    result_d.read_data = data_bus_in;
                    result_d.ok        = 1'b1;
                    state_d            = S_DONE;
                end else begin
                    result_d.read_data = data_bus_in;
                    fail_seen_d = fail_seen_q | mismatch;
                    if (!last_byte) begin
                        byte_d  = byte_q + 2'h1;
                        addr_d  = page_base + 17'(byte_q + 2'h1);
                        state_d = S_VERIFY_SETUP;
                    end else if (!(fail_seen_q | mismatch)) begin
                        result_d.ok = 1'b1;
                        state_d     = S_DONE;
                    end else if (out_of_pulses) begin
                        result_d.fail = 1'b1;
                        state_d       = S_DONE;
                    end else begin
                        // Retry: float the device data, drive the bus for a byte program only, and pulse again.
                        fail_seen_d = 1'b0;
                        pins_d.output_enable_n = 1'b1;
                        pins_d.chip_enable_n   = is_page ? 1'b1 : 1'b0;
                        addr_d  = is_page ? page_base : addr_q;
                        dout_d  = lane(cmd_q.data, 2'h0);
                        oe_d    = !is_page;
                        pins_d.program_strobe_n = 1'b0;
                        result_d.pulses = result_q.pulses + 4'h1;
                        count_d = PULSE_LEN;
                        state_d = S_PULSE;
                    end
                end
            end
            S_DONE: begin
                pins_d  = idle_pins;
                done_d  = 1'b1;
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q     <= S_IDLE;
            cmd_q       <= '0;
            result_q    <= '0;
            pins_q      <= '{chip_enable_n: 1'b1, output_enable_n: 1'b1,
                             program_strobe_n: 1'b1, reset_n: 1'b0, vpp_high: 1'b0};
            count_q     <= 17'h0_0000;
            byte_q      <= 2'h0;
            addr_q      <= '0;
            dout_q      <= '0;
            oe_q        <= 1'b0;
            ready_q     <= 1'b0;
            done_q      <= 1'b0;
            fail_seen_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            if (state_q == S_IDLE && cmd_valid && ready_q) begin
                cmd_q <= cmd;
            end
            result_q    <= result_d;
            pins_q      <= pins_d;
            count_q     <= count_d;
            byte_q      <= byte_d;
            addr_q      <= addr_d;
            dout_q      <= dout_d;
            oe_q        <= oe_d;
            ready_q     <= ready_d;
            done_q      <= done_d;
            fail_seen_q <= fail_seen_d;
        end
    end

    assign cmd_ready    = ready_q;
    assign done         = done_q;
    assign result       = result_q;
    assign pins         = pins_q;
    assign address_bus  = addr_q;
    assign data_bus_out = dout_q;
    assign data_bus_oe  = oe_q;

endmodule

/* File: shared/prom_prog_map.svh */
`ifndef PROM_PROG_MAP_SVH
`define PROM_PROG_MAP_SVH

// Pulse width of the program strobe in nanoseconds and the clock period.
`define PULSE_WIDTH_NS     100000
`define CLK_PERIOD_NS      20
// Longest pulse length in cycles, rounded down.
`define PULSE_CYCLES       (`PULSE_WIDTH_NS / `CLK_PERIOD_NS)
// Setup and hold spacing around strobe edges, in cycles.
`define SETUP_CYCLES       4
`define MAX_PULSES         10
`define PAGE_BYTES         4
`define ADDR_W             17
`define DATA_W             8

`endif

/* File: shared/prom_prog_pkg.sv */
package prom_prog_pkg;

    typedef enum logic [1:0] {
        OP_READ,
        OP_BYTE_PROGRAM,
        OP_PAGE_PROGRAM
    } op_t;

    typedef struct packed {
        op_t         op;
        logic [16:0] addr;
        logic [31:0] data;
    } cmd_t;

    typedef struct packed {
        logic        ok;
        logic        fail;
        logic [7:0]  read_data;
        logic [3:0]  pulses;
    } result_t;

    typedef struct packed {
        logic        chip_enable_n;
        logic        output_enable_n;
        logic        program_strobe_n;
        logic        reset_n;
        logic        vpp_high;
    } strobes_t;

endpackage

/* File: testbench/prom_programmer_sva.sv */
`timescale 1ns/10ps
`include "prom_prog_map.svh"
module prom_programmer_sva (
    // Clock and reset.
    input wire logic                    clk,
    input wire logic                    reset,
    // Command side.
    input wire logic                    cmd_valid,
    input wire prom_prog_pkg::cmd_t     cmd,
    input wire logic                    cmd_ready,
    input wire logic                    done,
    input wire prom_prog_pkg::result_t  result,
    // Device pins.
    input wire prom_prog_pkg::strobes_t pins,
    input wire logic [`ADDR_W-1:0]      address_bus,
    input wire logic [`DATA_W-1:0]      data_bus_out,
    input wire logic                    data_bus_oe,
    input wire logic [`DATA_W-1:0]      data_bus_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // Pulse bookkeeping
    localparam int PULSE = `PULSE_CYCLES;
    logic [12:0] low_q;
    logic [3:0]  npulse_q;
    logic        pgm_q;
    wire         strobe_n = pins.program_strobe_n;
    always_ff @(posedge clk) begin
        pgm_q <= strobe_n;
        low_q <= strobe_n ? 13'h0000 : low_q + 13'h0001;
        if (reset || (cmd_valid && cmd_ready)) begin
            npulse_q <= 4'h0;
        end else if (pgm_q && !strobe_n) begin
            npulse_q <= npulse_q + 4'h1;
        end
    end
    reset_held_a: assert property (pins.reset_n == 1'b0)
        else $error("device reset released");
    supply_up_a: assert property (!$past(reset) |-> pins.vpp_high)
        else $error("programming supply dropped");
    pulse_width_a: assert property ($rose(strobe_n) |-> low_q == PULSE)
        else $error("program pulse width wrong");
    pulse_oe_a: assert property (!strobe_n |-> pins.output_enable_n)
        else $error("output enable low during pulse");
    byte_data_a: assert property (!strobe_n && !pins.chip_enable_n |-> data_bus_oe)
        else $error("byte pulse without data");
    pulse_hold_a: assert property (!strobe_n && !pgm_q |-> $stable(address_bus) && $stable(pins.chip_enable_n))
        else $error("address or enable moved in pulse");
    verify_follows_a: assert property ($rose(strobe_n) |-> ##[1:20] (!pins.chip_enable_n && !pins.output_enable_n))
        else $error("no verify after pulse");
    pulse_limit_a: assert property (npulse_q <= 4'ha)
        else $error("too many pulses");
    fail_count_a: assert property (done && result.fail |-> npulse_q == 4'ha && result.pulses == 4'ha)
        else $error("failure flagged at wrong count");
    no_clash_a: assert property (data_bus_oe |-> pins.chip_enable_n || pins.output_enable_n || !strobe_n)
        else $error("bus driven while device drives");
    idle_quiet_a: assert property (cmd_ready |-> pins.chip_enable_n && pins.output_enable_n && strobe_n)
        else $error("strobes active while idle");
    cover property (done && result.fail);
    cover property (done && result.ok && result.pulses == 4'h3);
    cover property ($fell(strobe_n) && pins.chip_enable_n);
endmodule
bind prom_programmer prom_programmer_sva chk (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .result(result), .pins(pins),
    .address_bus(address_bus), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .data_bus_in(data_bus_in));

/* File: testbench/prom_device_model.sv */
`timescale 1ns/10ps
`include "prom_prog_map.svh"
module prom_device_model (
    // Clock for output timing and page latch capture.
    input  wire logic                    clk,
    // Programmer pins.
    input  wire prom_prog_pkg::strobes_t pins,
    input  wire logic [`ADDR_W-1:0]      address_bus,
    input  wire logic [`DATA_W-1:0]      data_bus_out,
    input  wire logic                    data_bus_oe,
    output logic [`DATA_W-1:0]           data_bus_in
);
    // ==========================================
    // Storage and pins
    logic [7:0]  mem [int];
    logic [7:0]  page_q [4];
    logic [16:0] base_q;
    logic        page_mode;
    logic [7:0]  bus_q = 8'h5a;
    int          fail_left = 0;
    wire mode_ok = pins.vpp_high === 1'b1 && pins.reset_n === 1'b0;
    wire drive = mode_ok && !pins.chip_enable_n && !pins.output_enable_n
                 && pins.program_strobe_n;
    // A floating bus shows the inverse of its last value so stale data never matches.
    always @(negedge clk) begin
        if (data_bus_oe) begin
            bus_q <= data_bus_out;
        end else if (drive) begin
            bus_q <= mem.exists(int'(address_bus)) ? mem[int'(address_bus)] : 8'hff;
        end else begin
            bus_q <= ~bus_q;
        end
    end
    assign data_bus_in = bus_q;
    always @(posedge clk) begin
        if (mode_ok && pins.chip_enable_n && !pins.output_enable_n
            && pins.program_strobe_n && data_bus_oe) begin
            page_q[address_bus[1:0]] <= data_bus_out;
            base_q <= {address_bus[16:2], 2'b00};
        end
    end
    always @(negedge pins.program_strobe_n) page_mode = pins.chip_enable_n;
    // Contents change only at the end of a pulse, so a high strobe leaves them alone.
    always @(posedge pins.program_strobe_n) begin
        if (mode_ok && pins.output_enable_n === 1'b1) begin
            if (fail_left > 0) begin
                fail_left--;
            end else if (page_mode) begin
                for (int i = 0; i < 4; i++) mem[int'(base_q) + i] = page_q[i];
            end else begin
                mem[int'(address_bus)] = data_bus_out;
            end
        end
    end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`include "prom_prog_map.svh"
module testbench;
    // ==========================================
    // Signals
    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    logic                    cmd_valid = 1'b0;
    prom_prog_pkg::cmd_t     cmd = '0;
    logic                    cmd_ready;
    logic                    done;
    prom_prog_pkg::result_t  result;
    prom_prog_pkg::strobes_t pins;
    logic [`ADDR_W-1:0]      address_bus;
    logic [`DATA_W-1:0]      data_bus_out;
    logic                    data_bus_oe;
    logic [`DATA_W-1:0]      data_bus_in;
    int                      bad_count = 0;
    int                      n_tests = 0;
    logic [13:0]             exp_q [$];
    logic [13:0]             msk_q [$];
    always #10 clk = ~clk;
    prom_programmer DUT (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .done(done), .result(result), .pins(pins),
        .address_bus(address_bus), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .data_bus_in(data_bus_in));
    prom_device_model model (.clk(clk), .pins(pins), .address_bus(address_bus),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in));
    task close_out;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp_res(input logic [13:0] e, input logic [13:0] m, input logic [13:0] g);
        n_tests++;
        if ((g & m) !== (e & m)) begin
            bad_count++;
            $display("[ERR] result expected %h seen %h", e & m, g & m);
        end
    endtask
    // Reads ignore the pulse count, which has no meaning for them.
    task run(input prom_prog_pkg::op_t op, input logic [16:0] a, input logic [31:0] d,
             input logic [13:0] e);
        int k;
        k = 0;
        exp_q.push_back(e);
        msk_q.push_back(op == prom_prog_pkg::OP_READ ? 14'h3ff0 : 14'h3fff);
        while (cmd_ready !== 1'b1 && k < 100) begin @(posedge clk); #1; k++; end
        if (k >= 100) begin
            bad_count++;
            $display("[ERR] cmd_ready expected 1 seen 0");
        end
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, a, d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 60000) begin @(posedge clk); #1; k++; end
        if (k >= 60000) begin
            bad_count++;
            $display("[ERR] done expected 1 seen 0");
        end
    endtask
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin bad_count++; $display("[ERR] done expected 0 seen 1"); end
            else cmp_res(exp_q.pop_front(), msk_q.pop_front(), result);
        end
    end
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        close_out;
    end
    initial begin
        logic [7:0]  b;
        logic [31:0] w;
        void'($urandom(32'hc6a8_7352));
        // Keep the byte off zero and off the erased value, so a missed write never matches.
        b = {1'b0, 7'($urandom)} | 8'h01;
        w = $urandom;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        run(prom_prog_pkg::OP_READ, 17'($urandom) | 17'h1_0000, 0, {2'b10, 8'hff, 4'h0});
        run(prom_prog_pkg::OP_BYTE_PROGRAM, 17'h0_0100, {24'h0, b}, {2'b10, b, 4'h1});
        run(prom_prog_pkg::OP_READ, 17'h0_0100, 0, {2'b10, b, 4'h0});
        model.fail_left = 2;
        run(prom_prog_pkg::OP_BYTE_PROGRAM, 17'h0_0101, {24'h0, ~b}, {2'b10, ~b, 4'h3});
        run(prom_prog_pkg::OP_PAGE_PROGRAM, 17'h0_0206, w, {2'b10, w[31:24], 4'h1});
        for (int i = 0; i < 4; i++) begin
            run(prom_prog_pkg::OP_READ, 17'h0_0204 + 17'(i), 0, {2'b10, w[8*i+:8], 4'h0});
        end
        model.fail_left = 99;
        run(prom_prog_pkg::OP_BYTE_PROGRAM, 17'h0_0300, {24'h0, b}, {2'b01, 8'hff, 4'ha});
        model.fail_left = 0;
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("[ERR] pending results expected 0 seen %0d", exp_q.size());
        end
        close_out;
    end
endmodule
